// ===== dpio_pkg.sv
// package: register map, field layout and codes of the io card decoder
package dpio_pkg;
  // byte offsets from the io base
  localparam logic [7:0] OFS_G1_PORT_A = 8'h00;
  localparam logic [7:0] OFS_G1_PORT_B = 8'h01;
  localparam logic [7:0] OFS_G1_PORT_C = 8'h02;
  localparam logic [7:0] OFS_G1_CTRL = 8'h03;
  localparam logic [7:0] OFS_G2_PORT_A = 8'h04;
  localparam logic [7:0] OFS_G2_PORT_B = 8'h05;
  localparam logic [7:0] OFS_G2_PORT_C = 8'h06;
  localparam logic [7:0] OFS_G2_CTRL = 8'h07;
  localparam logic [7:0] OFS_CNT_CH0 = 8'h10;
  localparam logic [7:0] OFS_CNT_CH1 = 8'h11;
  localparam logic [7:0] OFS_CNT_CH2 = 8'h12;
  localparam logic [7:0] OFS_CNT_MODE = 8'h13;
  localparam logic [7:0] OFS_IRQ_SRC = 8'h20;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h30;
  // configuration header offset holding the bridge register base
  localparam logic [7:0] OFS_CFG_LCR_BASE = 8'h14;
  // interrupt source select field positions
  localparam int IRQ1_SEL_LSB = 0;
  localparam int IRQ2_SEL_LSB = 2;
  // reset values and the read value of write-only and unmapped offsets
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [31:0] RST_LCR_BASE = 32'h0000_0000;
  localparam logic [7:0] RD_UNUSED = 8'hff;
  // interrupt source codes
  typedef enum logic [1:0] {
    DPIO_SRC_OFF = 2'h0,
    DPIO_SRC_FALL_C0 = 2'h1,
    DPIO_SRC_COMBO = 2'h2,
    DPIO_SRC_COUNT = 2'h3
  } dpio_src_e;
endpackage : dpio_pkg

// ===== dpio_irq_src.sv
// one interrupt source selector with its pending flag
`timescale 1ns/1ps
module dpio_irq_src
  import dpio_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // control
  input wire logic [1:0] sel_i,
  input wire logic clear_i,
  // synchronised port c bits and counter zero pulse
  input wire logic c0_i,
  input wire logic c3_i,
  input wire logic zero_i,
  // pending request
  output logic pend_o
);
  typedef struct packed {
    logic c0;
    logic c3;
    logic pend;
  } dpio_src_s;
  dpio_src_s st_r;
  dpio_src_s st_nxt;
  logic ev;

  // event detection per selected mode
  always_comb begin
    st_nxt = st_r;
    st_nxt.c0 = c0_i;
    st_nxt.c3 = c3_i;
    case (sel_i)
      DPIO_SRC_OFF: ev = 1'b0; // R9
      DPIO_SRC_FALL_C0: ev = st_r.c0 & ~c0_i; // R9
      DPIO_SRC_COMBO: begin
        // c3 falling while c0 low, or c0 rising while c3 high
        ev = (~c0_i & st_r.c3 & ~c3_i) |
             (~st_r.c0 & c0_i & c3_i); // R9
      end
      DPIO_SRC_COUNT: ev = zero_i; // R9
      default: ev = 1'b0;
    endcase
    // a new event wins over a clear in the same cycle
    if (ev) begin
      st_nxt.pend = 1'b1;
    end else if (clear_i) begin
      st_nxt.pend = 1'b0; // R10
    end
  end

  // state register
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pend_o = st_r.pend;
endmodule : dpio_irq_src

// ===== dpio_regs.sv
// byte register decoder of the dual port io card behind the bridge
//
// Behaviour
// R1: card answers as target, never masters
// R2: every register byte wide, byte access only
// R3: six port data registers, read and write
// R4: port control words write only
// R5: counter channels and mode control/status
// R6: interrupt select and clear write only
// R7: bridge register base held at 14h
// R8: host keeps firmware base and interrupt
// R9: two bit source select per interrupt
// R10: clear write drops pending interrupt request
`timescale 1ns/1ps
module dpio_regs
  import dpio_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // byte io access from the bridge local side
  input wire logic io_sel_i,
  input wire logic io_wr_i,
  input wire logic io_rd_i,
  input wire logic [7:0] io_addr_i,
  input wire logic [7:0] io_wdata_i,
  output logic [7:0] io_rdata_o,
  output logic io_ack_o,
  // configuration header access for the bridge register base
  input wire logic cfg_wr_i,
  input wire logic [7:0] cfg_addr_i,
  input wire logic [31:0] cfg_wdata_i,
  output logic [31:0] bridge_local_config_regs_o,
  // port group data towards the io lines
  output logic [7:0] group1_port_a_o,
  output logic [7:0] group1_port_b_o,
  output logic [7:0] group1_port_c_o,
  output logic [7:0] group1_control_word_o,
  output logic [7:0] group2_port_a_o,
  output logic [7:0] group2_port_b_o,
  output logic [7:0] group2_port_c_o,
  output logic [7:0] group2_control_word_o,
  output logic [5:0] port_wr_o,
  // port group line levels, asynchronous
  input wire logic [7:0] group1_port_a_i,
  input wire logic [7:0] group1_port_b_i,
  input wire logic [7:0] group1_port_c_i,
  input wire logic [7:0] group2_port_a_i,
  input wire logic [7:0] group2_port_b_i,
  input wire logic [7:0] group2_port_c_i,
  // counter block access
  output logic [1:0] cnt_sel_o,
  output logic [7:0] cnt_wdata_o,
  output logic cnt_wr_o,
  output logic cnt_mode_wr_o,
  output logic cnt_rd_o,
  input wire logic [7:0] cnt_rdata_i,
  input wire logic [7:0] cnt_status_i,
  input wire logic event_zero_i,
  input wire logic timer_zero_i,
  // interrupt requests
  output logic first_card_irq_o,
  output logic second_card_irq_o,
  output logic card_irq_o
);
  typedef struct packed {
    logic [7:0] g1a;
    logic [7:0] g1b;
    logic [7:0] g1c;
    logic [7:0] g1ctl;
    logic [7:0] g2a;
    logic [7:0] g2b;
    logic [7:0] g2c;
    logic [7:0] g2ctl;
    logic [3:0] isel;
    logic [31:0] bridge_local_config_regs;
    logic [7:0] rdata;
    logic ack;
    logic [5:0] pwr;
    logic [1:0] csel;
    logic [7:0] cwd;
    logic cwr;
    logic cmwr;
    logic clr;
    logic crd;
    logic [47:0] s1;
    logic [47:0] s2;
    logic [47:0] s3;
  } dpio_regs_s;
  dpio_regs_s st_r;
  dpio_regs_s st_nxt;
  logic [47:0] pins;
  logic [47:0] pin_val;
  logic wr;
  logic rd;

  assign pins = {group2_port_c_i, group2_port_b_i, group2_port_a_i,
                 group1_port_c_i, group1_port_b_i, group1_port_a_i};
  // a pin counts as changed once the change reaches stage three, whether or not stage two still agrees
  // a request still held while its ack stands is not taken a second time,
  // so a counter or clear strobe never fires twice for one host access
  assign wr = io_sel_i & io_wr_i & ~st_r.ack; // R1
  assign rd = io_sel_i & io_rd_i & ~io_wr_i & ~st_r.ack; // R1

  ////////////////////////////////////////////////////////////////////////
  // next state: decode, read mux, synchroniser
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = pins;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    pin_val = (st_r.s2 == st_r.s3) ? st_r.s2 : st_r.s3;
    st_nxt.ack = wr | rd;
    st_nxt.pwr = '0;
    st_nxt.cwr = 1'b0;
    st_nxt.cmwr = 1'b0;
    st_nxt.clr = 1'b0;
    st_nxt.crd = rd; // R5
    // bridge base kept in the header at its offset
    if (cfg_wr_i && cfg_addr_i == OFS_CFG_LCR_BASE) begin
      st_nxt.bridge_local_config_regs = cfg_wdata_i; // R7
    end
    // byte writes, upper address bits fully decoded
    if (wr) begin
      case (io_addr_i) // R2
        OFS_G1_PORT_A: begin st_nxt.g1a = io_wdata_i; st_nxt.pwr[0] = 1'b1; end // R3
        OFS_G1_PORT_B: begin st_nxt.g1b = io_wdata_i; st_nxt.pwr[1] = 1'b1; end // R3
        OFS_G1_PORT_C: begin st_nxt.g1c = io_wdata_i; st_nxt.pwr[2] = 1'b1; end // R3
        OFS_G1_CTRL: st_nxt.g1ctl = io_wdata_i; // R4
        OFS_G2_PORT_A: begin st_nxt.g2a = io_wdata_i; st_nxt.pwr[3] = 1'b1; end // R3
        OFS_G2_PORT_B: begin st_nxt.g2b = io_wdata_i; st_nxt.pwr[4] = 1'b1; end // R3
        OFS_G2_PORT_C: begin st_nxt.g2c = io_wdata_i; st_nxt.pwr[5] = 1'b1; end // R3
        OFS_G2_CTRL: st_nxt.g2ctl = io_wdata_i; // R4
        OFS_CNT_CH0, OFS_CNT_CH1, OFS_CNT_CH2: begin
          st_nxt.csel = io_addr_i[1:0]; // R5
          st_nxt.cwd = io_wdata_i;
          st_nxt.cwr = 1'b1;
        end
        OFS_CNT_MODE: begin
          st_nxt.cwd = io_wdata_i; // R5
          st_nxt.cmwr = 1'b1;
        end
        OFS_IRQ_SRC: st_nxt.isel = io_wdata_i[3:0]; // R6
        OFS_IRQ_CLR: st_nxt.clr = 1'b1; // R10
        default: ;
      endcase
    end
    // byte reads; write-only and unmapped offsets give all ones
    if (rd) begin
      case (io_addr_i)
        OFS_G1_PORT_A: st_nxt.rdata = pin_val[7:0]; // R3
        OFS_G1_PORT_B: st_nxt.rdata = pin_val[15:8];
        OFS_G1_PORT_C: st_nxt.rdata = pin_val[23:16];
        OFS_G2_PORT_A: st_nxt.rdata = pin_val[31:24];
        OFS_G2_PORT_B: st_nxt.rdata = pin_val[39:32];
        OFS_G2_PORT_C: st_nxt.rdata = pin_val[47:40];
        OFS_CNT_CH0, OFS_CNT_CH1, OFS_CNT_CH2: begin
          st_nxt.rdata = cnt_rdata_i; // R5
          st_nxt.csel = io_addr_i[1:0];
        end
        OFS_CNT_MODE: st_nxt.rdata = cnt_status_i; // R5
        default: st_nxt.rdata = RD_UNUSED; // R4 R6
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      st_r <= '0;
      st_r.bridge_local_config_regs <= RST_LCR_BASE;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupt sources, one per group
  dpio_irq_src u_src1 (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .sel_i(st_r.isel[IRQ1_SEL_LSB+:2]), // R9
    .clear_i(st_r.clr),
    .c0_i(pin_val[16]),
    .c3_i(pin_val[19]),
    .zero_i(event_zero_i),
    .pend_o(first_card_irq_o)
  );
  dpio_irq_src u_src2 (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .sel_i(st_r.isel[IRQ2_SEL_LSB+:2]), // R9
    .clear_i(st_r.clr),
    .c0_i(pin_val[40]),
    .c3_i(pin_val[43]),
    .zero_i(timer_zero_i),
    .pend_o(second_card_irq_o)
  );

  // outputs
  assign card_irq_o = first_card_irq_o | second_card_irq_o;
  assign io_rdata_o = st_r.rdata;
  assign io_ack_o = st_r.ack;
  assign bridge_local_config_regs_o = st_r.bridge_local_config_regs;
  assign group1_port_a_o = st_r.g1a;
  assign group1_port_b_o = st_r.g1b;
  assign group1_port_c_o = st_r.g1c;
  assign group1_control_word_o = st_r.g1ctl;
  assign group2_port_a_o = st_r.g2a;
  assign group2_port_b_o = st_r.g2b;
  assign group2_port_c_o = st_r.g2c;
  assign group2_control_word_o = st_r.g2ctl;
  assign port_wr_o = st_r.pwr;
  assign cnt_sel_o = st_r.csel;
  assign cnt_wdata_o = st_r.cwd;
  assign cnt_wr_o = st_r.cwr;
  assign cnt_mode_wr_o = st_r.cmwr;
  assign cnt_rd_o = st_r.crd;
endmodule : dpio_regs

// ===== dpio_regs_properties.sv
// checker: port properties of the io card register decoder
`timescale 1ns/1ps
module dpio_regs_properties (
  // watched ports
  input wire logic clk_i, reset_i, io_sel_i, io_wr_i, io_rd_i, io_ack_o,
  input wire logic [7:0] io_addr_i, io_wdata_i, io_rdata_o, group1_port_a_o,
  input wire logic [5:0] port_wr_o,
  input wire logic [1:0] cnt_sel_o,
  input wire logic cnt_wr_o, cnt_mode_wr_o,
  input wire logic first_card_irq_o, second_card_irq_o, card_irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // access decode helpers
  // a request is taken only while no ack stands
  wire acc = io_sel_i && (io_wr_i || io_rd_i) && !io_ack_o;
  wire wr = io_sel_i && io_wr_i && !io_ack_o;
  wire clr = wr && io_addr_i == 8'h30;
  ////////////////////////////////////////////////////////////////////////////
  chk_ack_follows: assert property (acc |=> io_ack_o)
    else $error("ack missing");
  chk_ack_caused: assert property (io_ack_o |-> $past(acc))
    else $error("ack without access");
  chk_port_write: assert property (wr && io_addr_i == 8'h00 |=>
    port_wr_o == 6'h01 && group1_port_a_o == $past(io_wdata_i))
    else $error("port write lost");
  chk_wr_pulse_cause: assert property (port_wr_o != 6'h00 |-> $past(wr))
    else $error("port strobe without write");
  chk_wo_read: assert property (io_sel_i && io_rd_i && !io_wr_i &&
    io_addr_i inside {8'h03, 8'h07, 8'h20, 8'h30} |=> io_rdata_o == 8'hff)
    else $error("write only read");
  chk_mode_write: assert property (wr && io_addr_i == 8'h13 |=>
    cnt_mode_wr_o && !cnt_wr_o) else $error("mode write");
  chk_chan_write: assert property (wr && io_addr_i inside {[8'h10:8'h12]}
    |=> cnt_wr_o && cnt_sel_o == $past(io_addr_i[1:0]))
    else $error("channel write");
  chk_irq_stands: assert property (first_card_irq_o && !clr &&
    !$past(clr) |=> first_card_irq_o) else $error("irq dropped");
  chk_irq_merge: assert property (card_irq_o ==
    (first_card_irq_o || second_card_irq_o)) else $error("irq merge");
  ////////////////////////////////////////////////////////////////////////////
  cover property (clr);
  cover property ($rose(first_card_irq_o));
  cover property (io_ack_o && io_rdata_o == 8'hff);
endmodule : dpio_regs_properties

// ===== dpio_host_model.sv
// host model: byte io master standing behind the bridge
`timescale 1ns/1ps
module dpio_host_model (
  // clock and answer
  input wire logic clk_i,
  input wire logic ack_i,
  input wire logic [7:0] rdata_i,
  // byte request, no header port: firmware base left alone
  output logic sel_o,
  output logic wr_o,
  output logic rd_o,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o
);
  // idle bus at time zero
  initial {sel_o, wr_o, rd_o, addr_o, wdata_o} = '0;
  // one byte access, held until ack is sampled or eight clocks pass
  task automatic acc(input logic w, input logic [7:0] a, d,
                     output logic [7:0] q, output logic ok);
    int n;
    @(posedge clk_i);
    sel_o <= 1'b1;
    wr_o <= w;
    rd_o <= !w;
    addr_o <= a;
    wdata_o <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_i !== 1'b1 && n < 8);
    ok = (ack_i === 1'b1);
    q = rdata_i;
    sel_o <= 1'b0;
    wr_o <= 1'b0;
    rd_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask : acc
endmodule : dpio_host_model

// ===== tb.sv
// testbench: host traffic, pin and counter stimulus around the decoder
`timescale 1ns/1ps
module tb;
  import dpio_pkg::*;
  logic clk_i = 1'b0, reset_i = 1'b1, cfg_wr_i = 1'b0;
  logic io_sel_i, io_wr_i, io_rd_i, io_ack_o, ok;
  logic [7:0] io_addr_i, io_wdata_i, io_rdata_o, cfg_addr_i = 8'h00;
  logic [31:0] cfg_wdata_i = '0, bridge_local_config_regs_o, v;
  logic [7:0] group1_port_a_o, group1_port_b_o, group1_port_c_o;
  logic [7:0] group1_control_word_o, group2_port_a_o, group2_port_b_o;
  logic [7:0] group2_port_c_o, group2_control_word_o;
  logic [7:0] group1_port_a_i, group1_port_b_i, group1_port_c_i;
  logic [7:0] group2_port_a_i, group2_port_b_i, group2_port_c_i;
  logic [5:0] port_wr_o;
  logic [1:0] cnt_sel_o;
  logic [7:0] cnt_wdata_o, cnt_rdata_i = '0, cnt_status_i = '0, q;
  logic cnt_wr_o, cnt_mode_wr_o, cnt_rd_o, event_zero_i = 1'b0;
  logic timer_zero_i = 1'b0, first_card_irq_o, second_card_irq_o, card_irq_o;
  logic [47:0] pins = '0;
  logic [7:0] lf = 8'h28;
  int n_fail = 0, check_count = 0, e;
  int mdl [8];
  int ofs_q [$] = '{0, 1, 2, 3, 4, 5, 6, 7, 'h20, 'h30, 'h40};
  wire [63:0] gq = {group2_control_word_o, group2_port_c_o, group2_port_b_o,
    group2_port_a_o, group1_control_word_o, group1_port_c_o,
    group1_port_b_o, group1_port_a_o};
  assign {group2_port_c_i, group2_port_b_i, group2_port_a_i, group1_port_c_i,
    group1_port_b_i, group1_port_a_i} = pins;
  // clock
  always #2.5 clk_i = ~clk_i;
  dpio_regs dpio_regs_i (.*);
  dpio_host_model dpio_host_model_i (.clk_i(clk_i), .ack_i(io_ack_o),
    .rdata_i(io_rdata_o), .sel_o(io_sel_i), .wr_o(io_wr_i), .rd_o(io_rd_i),
    .addr_o(io_addr_i), .wdata_o(io_wdata_i));
  ////////////////////////////////////////////////////////////////////////////
  function logic [7:0] rnd();
    lf = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
    return lf;
  endfunction : rnd
  task chk(input string nm, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task give_verdict;
    if (n_fail == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : give_verdict
  task io(input logic w, input logic [7:0] a, d);
    dpio_host_model_i.acc(w, a, d, q, ok);
    chk("ack", {31'h0, ok}, 32'h1);
    if (!ok) give_verdict;
  endtask : io
  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (6) @(posedge clk_i);
    reset_i <= 1'b0;
    v = {rnd(), rnd(), rnd(), rnd()};
    @(posedge clk_i);
    cfg_wr_i <= 1'b1;
    cfg_addr_i <= 8'h14;
    cfg_wdata_i <= v;
    @(posedge clk_i);
    cfg_addr_i <= 8'h10;
    cfg_wdata_i <= ~v;
    @(posedge clk_i);
    cfg_wr_i <= 1'b0;
    @(posedge clk_i);
    chk("bridge base", bridge_local_config_regs_o, v);
    pins <= {rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
    foreach (mdl[a]) begin
      mdl[a] = rnd();
      io(1'b1, 8'(a), 8'(mdl[a]));
      chk("port out", {24'h0, gq[a*8+:8]}, 32'(mdl[a]));
      e = (a % 4 == 3) ? 0 : 1 << (a - a / 4);
      chk("port strobe", {26'h0, port_wr_o}, 32'(e));
    end
    foreach (ofs_q[i]) begin
      io(1'b0, 8'(ofs_q[i]), 8'h00);
      e = ofs_q[i] / 4 * 3 + ofs_q[i] % 4;
      e = (ofs_q[i] < 8 && ofs_q[i] % 4 != 3) ? pins[e*8+:8] : 'hff;
      chk("read", {24'h0, q}, 32'(e));
    end
    cnt_rdata_i <= rnd();
    cnt_status_i <= rnd();
    for (int a = 'h10; a < 'h14; a++) begin
      io(1'b1, 8'(a), rnd());
      chk("cnt data", {24'h0, cnt_wdata_o}, {24'h0, lf});
      e = (a == 'h13) ? 2 : 4;
      chk("cnt strobe", {29'h0, cnt_wr_o, cnt_mode_wr_o, cnt_rd_o}, 32'(e));
      e = (a == 'h13) ? 2 : a % 4;
      chk("cnt sel", {30'h0, cnt_sel_o}, 32'(e));
      io(1'b0, 8'(a), 8'h00);
      e = (a == 'h13) ? cnt_status_i : cnt_rdata_i;
      chk("cnt read", {24'h0, q}, 32'(e));
      chk("cnt rd", {31'h0, cnt_rd_o}, 32'h1);
    end
    for (int k = 0; k < 4; k++) begin
      pins[23:16] <= (k == 2) ? 8'h08 : 8'h01;
      pins[47:40] <= (k == 2) ? 8'h08 : 8'h01;
      io(1'b1, 8'h20, 8'(k * 5));
      repeat (6) @(posedge clk_i);
      io(1'b1, 8'h30, rnd());
      pins[23:16] <= 8'h00;
      pins[47:40] <= 8'h00;
      event_zero_i <= (k == 3);
      timer_zero_i <= (k == 3);
      @(posedge clk_i);
      event_zero_i <= 1'b0;
      timer_zero_i <= 1'b0;
      repeat (8) @(posedge clk_i);
      e = (k != 0) ? 3 : 0;
      chk("irq set", {30'h0, first_card_irq_o, second_card_irq_o}, 32'(e));
      io(1'b1, 8'h30, rnd());
      repeat (2) @(posedge clk_i);
      chk("irq clear", {31'h0, card_irq_o}, 32'h0);
    end
    give_verdict;
  end
endmodule : tb
bind dpio_regs dpio_regs_properties dpio_regs_properties_i (.*);
